// >>> verilog/gp_gpio.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "gp_defines.svh"

// Function
// - ordinary pins tri-stated after reset
// - debug pins reset into debug function
// - port B bit 7 reverts to test reset
// - eight independent port instances, debug pins only on ports B and C
// - direction bit selects input capture or drive
// - data register decodes 256 masked addresses
// - data write changes only address-masked bits
// - data read returns zero for unmasked bits
// - one combined interrupt output per port
// - edge interrupt latched until software clears
// - mask bit gates pin onto interrupt
// - raw status unmasked, masked status gated
// - clear register: one clears, zero ignored
// - sense reprogramming may raise spurious interrupts
// - masked port B bit 4 event triggers converter
// - alternate select hands pin to peripheral
// - protected selects need unlock and commit bit
// - pad controls drive, drain, pulls, slew, enable
// - read-only peripheral and cell identification registers
module gp_port #(
    parameter logic [7:0] DBG_MASK = 8'h00,
    parameter logic [7:0] ID_SEED  = 8'h5A  // arbitrary identification value
) (
    input  wire logic           clock,      // system clock
    input  wire logic           rst,        // sync reset, high
    input  wire gp_pkg::gp_req_t req,       // bus request, this port only
    output logic [31:0]         rdata,      // read data, cycle after rd
    input  wire logic [7:0]     pin_in,     // pad input levels
    output logic [7:0]          pin_out,    // pad output levels
    output logic [7:0]          pin_oe,     // pad output enables
    input  wire logic [7:0]     alt_out,    // peripheral drive values
    input  wire logic [7:0]     alt_oe,     // peripheral drive enables
    output logic [7:0]          alt_in,     // pad levels to peripherals
    output gp_pkg::gp_pad_t     pad_ctl,    // pad electrical settings
    output logic [7:0]          afsel,      // alternate function select
    output logic                irq,        // combined port interrupt
    output logic                adc_trig    // masked bit-4 event pulse
);
    logic [7:0] data_q, dir_q, is_q, ibe_q, iev_q, im_q, edge_q, prev_q;
    logic [7:0] afsel_q, dr2_q, dr4_q, dr8_q, odr_q, pur_q, pdr_q, slr_q, den_q, cr_q;
    logic       lock_q, irq_q, adc_q, adc_prev_q;
    logic [31:0] rdata_q, rd_mux;
    logic [7:0] pin_den, mask, w8, clr, rise, fall, edge_evt, lvl, raw, mis, commit_ok;
    logic       data_sel;

    assign w8       = req.wdata[7:0];
    assign data_sel = (req.addr <= `GP_DATA_HI);
    assign mask     = req.addr[`GP_MASK_MSB:`GP_MASK_LSB];
    assign pin_den  = pin_in & den_q;
    assign clr      = (req.wr && req.addr == `GP_ICR) ? w8 : 8'h00;

    // output path: peripheral owns the pin when selected
    always_comb begin
        logic [7:0] val;
        logic [7:0] en;
        val = (afsel_q & alt_out) | (~afsel_q & data_q);
        en  = (afsel_q & alt_oe) | (~afsel_q & dir_q);
        // open drain only pulls low, a high lets the pad float
        pin_out = val & ~odr_q;
        pin_oe  = en & den_q & ~(odr_q & val);
    end
    assign alt_in  = pin_den & afsel_q;
    assign afsel   = afsel_q;
    assign pad_ctl = '{den: den_q, pd: pdr_q, pu: pur_q, slr: slr_q,
                       odr: odr_q, dr8: dr8_q, dr4: dr4_q, dr2: dr2_q};

    // data register: inputs sampled every cycle, outputs written through the mask
    always_ff @(posedge clock) begin
        if (rst) begin
            data_q <= `GP_RST_ZERO;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!dir_q[i]) begin
                    data_q[i] <= pin_den[i];
                end else if (req.wr && data_sel && mask[i]) begin
                    data_q[i] <= w8[i];
                end
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge clock) begin
        if (rst) begin
            dir_q <= `GP_RST_ZERO;
            is_q  <= `GP_RST_ZERO;
            ibe_q <= `GP_RST_ZERO;
            iev_q <= `GP_RST_ZERO;
            im_q  <= `GP_RST_ZERO;
            odr_q <= `GP_RST_ZERO;
            slr_q <= `GP_RST_ZERO;
        end else if (req.wr) begin
            unique case (req.addr)
                `GP_DIR: dir_q <= w8;
                // no shadowing here: a new sense setting may fire at once
                `GP_IS:  is_q  <= w8;
                `GP_IBE: ibe_q <= w8;
                `GP_IEV: iev_q <= w8;
                `GP_IM:  im_q  <= w8;
                `GP_ODR: odr_q <= w8;
                `GP_SLR: slr_q <= w8;
                default: ;
            endcase
        end
    end

    // drive strength: the three selects are mutually exclusive
    always_ff @(posedge clock) begin
        if (rst) begin
            dr2_q <= `GP_RST_DR2;
            dr4_q <= `GP_RST_ZERO;
            dr8_q <= `GP_RST_ZERO;
        end else if (req.wr) begin
            unique case (req.addr)
                `GP_DR2: begin
                    dr2_q <= w8;
                    dr4_q <= dr4_q & ~w8;
                    dr8_q <= dr8_q & ~w8;
                end
                `GP_DR4: begin
                    dr4_q <= w8;
                    dr2_q <= dr2_q & ~w8;
                    dr8_q <= dr8_q & ~w8;
                end
                `GP_DR8: begin
                    dr8_q <= w8;
                    dr2_q <= dr2_q & ~w8;
                    dr4_q <= dr4_q & ~w8;
                end
                default: ;
            endcase
        end
    end

    // pulls are mutually exclusive as well; debug pins come up pulled high
    always_ff @(posedge clock) begin
        if (rst) begin
            pur_q <= DBG_MASK;
            pdr_q <= `GP_RST_ZERO;
            den_q <= DBG_MASK;
        end else if (req.wr) begin
            unique case (req.addr)
                `GP_PUR: begin
                    pur_q <= w8;
                    pdr_q <= pdr_q & ~w8;
                end
                `GP_PDR: begin
                    pdr_q <= w8;
                    pur_q <= pur_q & ~w8;
                end
                `GP_DEN: den_q <= w8;
                default: ;
            endcase
        end
    end

    // commit protection guards debug pins against stray writes
    assign commit_ok = {8{~lock_q}} & cr_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            lock_q  <= 1'b1;
            cr_q    <= ~DBG_MASK;
            afsel_q <= DBG_MASK;
        end else if (req.wr) begin
            unique case (req.addr)
                `GP_LOCK: lock_q <= (req.wdata != `GP_LOCK_KEY);
                `GP_CR: begin
                    if (!lock_q) begin
                        cr_q <= (cr_q & ~DBG_MASK) | (w8 & DBG_MASK);
                    end
                end
                `GP_AFSEL: begin
                    afsel_q <= (afsel_q & DBG_MASK & ~commit_ok)
                             | (w8 & ~(DBG_MASK & ~commit_ok));
                end
                default: ;
            endcase
        end
    end

    // interrupt detection; inputs are synchronous already
    assign rise     = pin_den & ~prev_q;
    assign fall     = ~pin_den & prev_q;
    assign edge_evt = ~is_q & ((ibe_q & (rise | fall))
                    | (~ibe_q & ((iev_q & rise) | (~iev_q & fall))));
    assign lvl      = is_q & ((iev_q & pin_den) | (~iev_q & ~pin_den));
    assign raw      = (edge_q & ~is_q) | lvl;
    assign mis      = raw & im_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            prev_q <= `GP_RST_ZERO;
            edge_q <= `GP_RST_ZERO;
        end else begin
            prev_q <= pin_den;
            // a new edge in the clearing cycle survives the clear
            edge_q <= (edge_q & ~clr) | edge_evt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q      <= 1'b0;
            adc_q      <= 1'b0;
            adc_prev_q <= 1'b0;
        end else begin
            irq_q      <= |mis;
            adc_prev_q <= mis[`GP_ADC_BIT];
            adc_q      <= mis[`GP_ADC_BIT] & ~adc_prev_q;
        end
    end
    assign irq      = irq_q;
    assign adc_trig = adc_q;

    // read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (data_sel) begin
            rd_mux[7:0] = data_q & mask;
        end else if (req.addr >= `GP_PID_BASE && req.addr[1:0] == 2'b00) begin
            rd_mux[7:0] = ID_SEED + 8'(req.addr[5:2]);
        end else begin
            unique case (req.addr)
                `GP_DIR:   rd_mux[7:0] = dir_q;
                `GP_IS:    rd_mux[7:0] = is_q;
                `GP_IBE:   rd_mux[7:0] = ibe_q;
                `GP_IEV:   rd_mux[7:0] = iev_q;
                `GP_IM:    rd_mux[7:0] = im_q;
                `GP_RIS:   rd_mux[7:0] = raw;
                `GP_MIS:   rd_mux[7:0] = mis;
                `GP_AFSEL: rd_mux[7:0] = afsel_q;
                `GP_DR2:   rd_mux[7:0] = dr2_q;
                `GP_DR4:   rd_mux[7:0] = dr4_q;
                `GP_DR8:   rd_mux[7:0] = dr8_q;
                `GP_ODR:   rd_mux[7:0] = odr_q;
                `GP_PUR:   rd_mux[7:0] = pur_q;
                `GP_PDR:   rd_mux[7:0] = pdr_q;
                `GP_SLR:   rd_mux[7:0] = slr_q;
                `GP_DEN:   rd_mux[7:0] = den_q;
                `GP_LOCK:  rd_mux[0]   = lock_q;
                `GP_CR:    rd_mux[7:0] = cr_q;
                default:   rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= req.rd ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata = rdata_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_RST_OFF: assert property (@(posedge clock) disable iff (1'b0)
        rst |=> ((pdr_q == 8'h00) && ((afsel_q | den_q | pur_q) & ~DBG_MASK) == 8'h00))
        else $error("ordinary pin not tri-stated after reset");
    AST_RST_DBG: assert property (@(posedge clock) disable iff (1'b0)
        rst |=> ((afsel_q & den_q & pur_q & DBG_MASK) == DBG_MASK))
        else $error("debug pin not in debug function after reset");
    AST_IN_CAPTURE: assert property (
        1'b1 |=> ((data_q & ~$past(dir_q)) == ($past(pin_den) & ~$past(dir_q))))
        else $error("input level not captured into data bit");
    AST_OUT_DRIVE: assert property (
        ((pin_oe ^ (dir_q & den_q & ~(odr_q & data_q))) & ~afsel_q) == 8'h00)
        else $error("software pin enable disagrees with direction");
    AST_MASK_WRITE: assert property (
        (req.wr && data_sel) |=> (((data_q ^ $past(data_q)) & $past(dir_q) & ~$past(mask)) == 8'h00
                                  && ((data_q ^ $past(w8)) & $past(dir_q) & $past(mask)) == 8'h00))
        else $error("masked data write wrong");
    AST_MASK_READ: assert property (
        (req.rd && data_sel) |=> (rdata == {24'h000000, $past(data_q) & $past(mask)}))
        else $error("masked data read wrong");
    AST_EDGE_HOLD: assert property (
        1'b1 |=> (($past(edge_q) & ~$past(clr) & ~edge_q) == 8'h00))
        else $error("edge latch dropped without a clear");
    AST_CLEAR: assert property (
        (clr != 8'h00) |=> ((edge_q & $past(clr) & ~$past(edge_evt)) == 8'h00))
        else $error("clear did not remove latched edge");
    AST_IRQ: assert property (
        1'b1 |=> (irq == |($past(raw) & $past(im_q))))
        else $error("port interrupt not the or of masked status");
    AST_MIS_READ: assert property (
        (req.rd && req.addr == `GP_MIS) |=> (rdata[7:0] == ($past(raw) & $past(im_q))))
        else $error("masked status read wrong");
    AST_COMMIT: assert property (
        (req.wr && req.addr == `GP_AFSEL && lock_q)
            |=> (((afsel_q ^ $past(afsel_q)) & DBG_MASK) == 8'h00))
        else $error("protected select changed while locked");
    AST_ADC: assert property (
        (mis[`GP_ADC_BIT] && !adc_prev_q) |=> adc_trig ##1 !adc_trig)
        else $error("bit-4 trigger pulse wrong");

    COV_EDGE_IRQ:   cover property (edge_evt != 8'h00 ##1 irq);
    COV_MASK_WRITE: cover property (req.wr && data_sel && mask != 8'hFF && mask != 8'h00);
    COV_UNLOCK:     cover property (req.wr && req.addr == `GP_AFSEL && commit_ok != 8'h00);
    COV_SET_CLEAR:  cover property ((clr & edge_evt) != 8'h00);
endmodule

module gp_gpio (
    input  wire logic               clock,      // system clock, 250 MHz
    input  wire logic               rst,        // sync reset, high
    input  wire logic [14:0]        addr,       // [14:12] port, [11:0] offset
    input  wire logic [31:0]        wdata,      // write data
    input  wire logic               wr,         // write strobe
    input  wire logic               rd,         // read strobe
    output logic [31:0]             rdata,      // read data, cycle after rd
    input  wire logic [7:0][7:0]    pin_in,     // pad inputs per port
    output logic [7:0][7:0]         pin_out,    // pad outputs per port
    output logic [7:0][7:0]         pin_oe,     // pad enables per port
    input  wire logic [7:0][7:0]    alt_out,    // peripheral drive values
    input  wire logic [7:0][7:0]    alt_oe,     // peripheral drive enables
    output logic [7:0][7:0]         alt_in,     // pad levels to peripherals
    output gp_pkg::gp_pad_t [7:0]   pad_ctl,    // pad settings per port
    output logic [7:0]              irq,        // one interrupt per port
    output logic                    adc_trig,   // converter trigger pulse
    output logic                    test_rst_n  // test controller reset, low
);
    logic [7:0][31:0] rdata_p;
    logic [7:0][7:0]  afsel_p;
    logic [7:0]       adc_p;

    for (genvar i = 0; i < 8; i++) begin : g_port
        gp_port #(
            .DBG_MASK ((i == `GP_PORT_B) ? `GP_DBG_MASK_B :
                       (i == `GP_PORT_C) ? `GP_DBG_MASK_C : 8'h00),
            .ID_SEED  (8'h5A)
        ) u_port (
            .clock    (clock),
            .rst      (rst),
            .req      ('{addr: addr[11:0], wdata: wdata,
                         wr: wr && addr[14:12] == 3'(i), rd: rd && addr[14:12] == 3'(i)}),
            .rdata    (rdata_p[i]),
            .pin_in   (pin_in[i]),
            .pin_out  (pin_out[i]),
            .pin_oe   (pin_oe[i]),
            .alt_out  (alt_out[i]),
            .alt_oe   (alt_oe[i]),
            .alt_in   (alt_in[i]),
            .pad_ctl  (pad_ctl[i]),
            .afsel    (afsel_p[i]),
            .irq      (irq[i]),
            .adc_trig (adc_p[i])
        );
    end

    // unselected ports hold zero, so an or is a safe merge
    always_comb begin
        rdata = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            rdata = rdata | rdata_p[i];
        end
    end

    assign adc_trig   = adc_p[`GP_PORT_B];
    // a low on this pin during debug resets the test controller
    assign test_rst_n = afsel_p[`GP_PORT_B][`GP_TRST_BIT]
                      ? pin_in[`GP_PORT_B][`GP_TRST_BIT] : 1'b1;
endmodule
`default_nettype wire

// >>> verilog/gp_defines.svh
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// per-port register offsets, byte addresses within a 4 KB port window
`define GP_DATA_LO      12'h000
`define GP_DATA_HI      12'h3FC
`define GP_DIR          12'h400
`define GP_IS           12'h404
`define GP_IBE          12'h408
`define GP_IEV          12'h40C
`define GP_IM           12'h410
`define GP_RIS          12'h414
`define GP_MIS          12'h418
`define GP_ICR          12'h41C
`define GP_AFSEL        12'h420
`define GP_DR2          12'h500
`define GP_DR4          12'h504
`define GP_DR8          12'h508
`define GP_ODR          12'h50C
`define GP_PUR          12'h510
`define GP_PDR          12'h514
`define GP_SLR          12'h518
`define GP_DEN          12'h51C
`define GP_LOCK         12'h520
`define GP_CR           12'h524
`define GP_PID_BASE     12'hFD0
`define GP_CID_BASE     12'hFF0

// data mask field inside the address
`define GP_MASK_LSB     2
`define GP_MASK_MSB     9

// reset values and unlock key
`define GP_RST_ZERO     8'h00
`define GP_RST_DR2      8'hFF
`define GP_LOCK_KEY     32'hC0DE0001

// debug pins: port 1 bit 7, port 2 bits 3..0
`define GP_PORT_B       1
`define GP_PORT_C       2
`define GP_DBG_MASK_B   8'h80
`define GP_DBG_MASK_C   8'h0F
`define GP_TRST_BIT     7
`define GP_ADC_BIT      4

`endif

// >>> verilog/gp_pkg.sv
package gp_pkg;
    typedef struct packed {
        logic [7:0] den;
        logic [7:0] pd;
        logic [7:0] pu;
        logic [7:0] slr;
        logic [7:0] odr;
        logic [7:0] dr8;
        logic [7:0] dr4;
        logic [7:0] dr2;
    } gp_pad_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } gp_req_t;
endpackage

// >>> sim/gp_pins_model.sv
`timescale 1ns/100ps
`default_nettype none

module gp_pins_model (
    input  wire logic             clock,    // system clock
    input  wire logic [7:0][7:0]  pin_out,  // design pad values
    input  wire logic [7:0][7:0]  pin_oe,   // design pad enables
    input  wire gp_pkg::gp_pad_t [7:0] pad_ctl, // pulls
    input  wire logic [7:0][7:0]  ext_val,  // outside source level
    input  wire logic [7:0][7:0]  ext_en,   // outside source drives
    input  wire logic [7:0][7:0]  per_val,  // peripheral drive value
    input  wire logic [7:0][7:0]  per_en,   // peripheral drive enable
    output logic [7:0][7:0]       pin_in,   // resolved pad level
    output logic [7:0][7:0]       alt_out,  // to design
    output logic [7:0][7:0]       alt_oe    // to design
);
    logic [7:0][7:0] last_q;

    always_ff @(posedge clock) begin
        last_q <= pin_in;
    end

    // floating pad flips so a stale value never reads as valid
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (pin_oe[p][b]) begin
                    pin_in[p][b] = pin_out[p][b];
                end else if (ext_en[p][b]) begin
                    pin_in[p][b] = ext_val[p][b]; // source holds level until seen
                end else if (pad_ctl[p].pu[b]) begin
                    pin_in[p][b] = 1'b1;
                end else if (pad_ctl[p].pd[b]) begin
                    pin_in[p][b] = 1'b0;
                end else begin
                    pin_in[p][b] = ~last_q[p][b];
                end
            end
        end
    end

    assign alt_out = per_val;
    assign alt_oe  = per_en;
endmodule

`default_nettype wire

// >>> sim/gp_gpio_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "gp_defines.svh"

module gp_gpio_test;
    typedef struct {logic [2:0] p; logic [11:0] o; logic w; logic [31:0] d; logic [31:0] e;} gp_row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [14:0] addr = 15'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0][7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in;
    logic [7:0][7:0] ext_val = '0;
    logic [7:0][7:0] ext_en = '0;
    logic [7:0][7:0] per_val = '0;
    logic [7:0][7:0] per_en = '0;
    gp_pkg::gp_pad_t [7:0] pad_ctl;
    logic [7:0] irq;
    logic adc_trig, test_rst_n;
    int n_errors = 0;
    int check_count = 0;
    gp_row_t rows[14] = '{
        '{3'd1, `GP_AFSEL, 1'b0, 32'h0, 32'h80}, '{3'd2, `GP_AFSEL, 1'b0, 32'h0, 32'h0F},
        '{3'd0, `GP_AFSEL, 1'b0, 32'h0, 32'h00}, '{3'd1, `GP_DEN, 1'b0, 32'h0, 32'h80},
        '{3'd2, `GP_PUR, 1'b0, 32'h0, 32'h0F}, '{3'd0, `GP_PDR, 1'b0, 32'h0, 32'h00},
        '{3'd1, `GP_CR, 1'b1, 32'hFF, 32'h7F}, '{3'd2, `GP_CR, 1'b0, 32'h0, 32'hF0},
        '{3'd0, `GP_DR2, 1'b0, 32'h0, 32'hFF}, '{3'd1, `GP_LOCK, 1'b0, 32'h0, 32'h01},
        '{3'd1, `GP_AFSEL, 1'b1, 32'h00, 32'h80}, '{3'd0, 12'h600, 1'b1, 32'hFF, 32'h00},
        '{3'd0, `GP_PID_BASE, 1'b1, 32'h00, 32'h5E}, '{3'd0, `GP_DIR, 1'b0, 32'h0, 32'h00}
    };

    always #2 clock = ~clock;

    gp_gpio dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .pad_ctl(pad_ctl),
        .irq(irq), .adc_trig(adc_trig), .test_rst_n(test_rst_n));

    gp_pins_model pads_u (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
        .pad_ctl(pad_ctl), .ext_val(ext_val), .ext_en(ext_en), .per_val(per_val),
        .per_en(per_en), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask

    task automatic wr_reg(input logic [2:0] p, input logic [11:0] o, input logic [31:0] d);
        @(posedge clock);
        addr <= {p, o};
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] p, input logic [11:0] o, output logic [31:0] v);
        @(posedge clock);
        addr <= {p, o};
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    initial begin
        #(4 * 20000);
        n_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        tally_and_finish();
    end

    initial begin
        logic [31:0] v;
        ext_en[1] = 8'h90; // bit7 test reset held low, bit4 trigger source
        ext_en[3] = 8'hFF;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        tick(1);
        chk_pin("pin_oe0", 8'h00, pin_oe[0]);
        chk_pin("pad0_pu", 8'h00, pad_ctl[0].pu);
        chk_pin("pad2_den", 8'h0F, pad_ctl[2].den);
        chk_pin("test_rst_n", 8'h00, {7'h0, test_rst_n});
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].p, rows[i].o, rows[i].d);
            rd_reg(rows[i].p, rows[i].o, v);
            chk_reg($sformatf("row%0d", i), rows[i].e, v);
        end
        $display("test reset table done");
        wr_reg(3'd0, `GP_DEN, 32'hFF);
        wr_reg(3'd0, `GP_DIR, 32'hFF);
        wr_reg(3'd0, 12'h3FC, 32'h00);
        wr_reg(3'd0, 12'h098, 32'hEB);
        rd_reg(3'd0, 12'h3FC, v);
        chk_reg("data_wr", 32'h22, v);
        rd_reg(3'd0, 12'h0C4, v);
        chk_reg("data_rd", 32'h20, v);
        wr_reg(3'd0, 12'h3FC, 32'hD9);
        rd_reg(3'd0, 12'h0C4, v);
        chk_reg("data_rd2", 32'h11, v);
        chk_pin("pin_out0", 8'hD9, pin_out[0]);
        chk_pin("pin_oe0b", 8'hFF, pin_oe[0]);
        $display("test data done");
        wr_reg(3'd3, `GP_DEN, 32'hFF);
        @(posedge clock);
        ext_val[3] <= 8'hA4;
        tick(3);
        rd_reg(3'd3, 12'h3FC, v);
        chk_reg("data_in", 32'hA4, v);
        // program with mask off so reprogramming glitches are discarded
        wr_reg(3'd3, `GP_IS, 32'h08);
        wr_reg(3'd3, `GP_IBE, 32'h02);
        wr_reg(3'd3, `GP_IEV, 32'h09);
        wr_reg(3'd3, `GP_ICR, 32'hFF);
        @(posedge clock);
        ext_val[3] <= 8'hA7;
        tick(4);
        rd_reg(3'd3, `GP_RIS, v);
        chk_reg("ris_edge", 32'h03, v);
        rd_reg(3'd3, `GP_MIS, v);
        chk_reg("mis_off", 32'h00, v);
        chk_pin("irq_off", 8'h00, irq);
        wr_reg(3'd3, `GP_IM, 32'h09);
        tick(3);
        chk_pin("irq_on", 8'h08, irq);
        @(posedge clock);
        ext_val[3] <= 8'hAF;
        tick(4);
        rd_reg(3'd3, `GP_RIS, v);
        chk_reg("ris_lvl", 32'h0B, v);
        wr_reg(3'd3, `GP_ICR, 32'h00);
        rd_reg(3'd3, `GP_MIS, v);
        chk_reg("icr_zero", 32'h09, v);
        wr_reg(3'd3, `GP_ICR, 32'h03);
        @(posedge clock);
        ext_val[3] <= 8'hA7;
        tick(4);
        rd_reg(3'd3, `GP_RIS, v);
        chk_reg("ris_clr", 32'h00, v);
        chk_pin("irq_clr", 8'h00, irq);
        $display("test interrupts done");
        wr_reg(3'd1, `GP_DEN, 32'h90);
        wr_reg(3'd1, `GP_IEV, 32'h10);
        wr_reg(3'd1, `GP_ICR, 32'hFF);
        wr_reg(3'd1, `GP_IM, 32'h10);
        @(posedge clock);
        ext_val[1] <= 8'h10;
        for (int i = 0; i < 8 && adc_trig !== 1'b1; i++) tick(1);
        chk_pin("adc_trig", 8'h01, {7'h0, adc_trig});
        tick(1);
        chk_pin("adc_pulse", 8'h00, {7'h0, adc_trig});
        chk_pin("irq_b", 8'h02, irq);
        $display("test converter trigger done");
        wr_reg(3'd1, `GP_LOCK, `GP_LOCK_KEY);
        wr_reg(3'd1, `GP_CR, 32'h80);
        wr_reg(3'd1, `GP_AFSEL, 32'h00);
        rd_reg(3'd1, `GP_AFSEL, v);
        chk_reg("afsel_commit", 32'h00, v);
        chk_pin("trst_gpio", 8'h01, {7'h0, test_rst_n});
        per_val[0] <= 8'h00;
        per_en[0] <= 8'h01;
        wr_reg(3'd0, `GP_AFSEL, 32'h01);
        tick(1);
        chk_pin("alt_oe", 8'hFF, pin_oe[0]);
        chk_pin("alt_out", 8'hD8, pin_out[0]);
        chk_pin("alt_in", 8'h00, alt_in[0]);
        wr_reg(3'd4, `GP_ODR, 32'h3C);
        wr_reg(3'd4, `GP_SLR, 32'hC3);
        wr_reg(3'd4, `GP_DR8, 32'h0F);
        wr_reg(3'd4, `GP_PDR, 32'h50);
        tick(1);
        chk_pin("odr4", 8'h3C, pad_ctl[4].odr);
        chk_pin("slr4", 8'hC3, pad_ctl[4].slr);
        chk_pin("dr8_4", 8'h0F, pad_ctl[4].dr8);
        chk_pin("pd4", 8'h50, pad_ctl[4].pd);
        chk_pin("slr5", 8'h00, pad_ctl[5].slr);
        $display("test mode and pads done");
        @(posedge clock);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk_pin("trst_again", 8'h00, {7'h0, test_rst_n});
        rd_reg(3'd1, `GP_AFSEL, v);
        chk_reg("afsel_rst", 32'h80, v);
        chk_pin("pad4_odr_rst", 8'h00, pad_ctl[4].odr);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
